// ==== dv/test_display_ext_control_regs.sv ====
/*
 * self-checking bench for the extended display control register bank.
 * assumes the design's package is compiled first; the bench drives the inputs
 * itself on the rising edge of a 40 MHz clock, except the strap pins before the second reset, which change 1 ns after an edge; CE_IN is tied high.
 */
`timescale 1ns/100ps
`default_nettype none
module test_display_ext_control_regs;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'h0;
  logic resetn_n = 1'h0;
  dispctl_pkg::req_s req = '0;
  logic [3:0] pins = 4'hA;
  logic [4:0] cfg = 5'h16;
  logic blank_in = 1'h1, de_in = 1'h0, pre_in = 1'h0, de_sel = 1'h0;
  logic a80 = 1'h0, cga_in = 1'h0, ilace = 1'h0;
  logic [1:0] misc = 2'h0;
  logic [7:0] rdata;
  logic rvalid, blank_out, pclk, vid_oe_n, mem_oe_n, cga_out, pal, compat, sh256;
  logic sense, emul, clk_lock, gfx_lock, dot_lock, mfg, dac_off, half_en;
  logic [7:0] half;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic G = dispctl_pkg::SPACE_GFX;
  localparam logic C = dispctl_pkg::SPACE_CRT;
  localparam logic [7:0] SW_VAL = 8'h6F;

  always #12.5 clk = ~clk;

  display_ext_control_regs dut (.CLK_IN(clk), .RESETN_IN(resetn_n), .CE_IN(1'h1), .REG_REQ_IN(req),
    .RDATA_OUT(rdata), .RD_VALID_OUT(rvalid), .MEM_DATA_STRAP_PINS_IN(pins), .STRAP_CONFIG_IN(cfg),
    .BLANK_IN(blank_in), .DISP_EN_IN(de_in), .PRE_DISP_EN_IN(pre_in), .DE_TIMING_SEL_IN(de_sel),
    .ALPHA80_CGA_IN(a80), .CGA_VIDEO_EN_IN(cga_in), .MISC_SEL_IN(misc), .INTERLACE_EN_IN(ilace),
    .BLANK_OUT(blank_out), .PCLK_SRC_OUT(pclk), .VID_OE_N_OUT(vid_oe_n), .MEM_OE_N_OUT(mem_oe_n),
    .CGA_VIDEO_EN_OUT(cga_out), .PALETTE_LOCK_OUT(pal), .COMPAT_OUT(compat), .SHIFT256_OUT(sh256),
    .SWITCH_SENSE_OUT(sense), .EMUL_ANALOG_OUT(emul), .CLK_SEL_LOCK_OUT(clk_lock),
    .GFX_SEQ_LOCK_OUT(gfx_lock), .DOT89_LOCK_OUT(dot_lock), .MFG_TEST_OUT(mfg),
    .DAC_OFF_OUT(dac_off), .HALF_START_OUT(half), .HALF_START_EN_OUT(half_en));

  // ****************************************
  // report and compare tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask

  // a hang anywhere ends the run through the same closing path
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic wr(input logic s, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    req <= '{space: s, index: i, wr: 1'h1, rd: 1'h0, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // answer is registered on the taking edge itself, so look just after it
  task automatic rd(input logic s, input logic [7:0] i, input logic [7:0] exp);
    @(posedge clk);
    req <= '{space: s, index: i, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk1("read valid", 1'h1, rvalid);
    chk8("read data", exp, rdata);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn_n <= 1'h0;
    repeat (5) @(posedge clk);
    resetn_n <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset();
    rd(G, 8'h0F, 8'h68);
    rd(G, 8'h0E, 8'h00);
    rd(C, 8'h29, 8'hFF);
    chk1("blank pass", 1'h1, blank_out);
    chk1("vid float", 1'h0, vid_oe_n);
    end_test("reset");

    wr(G, 8'h0E, 8'hFF);
    rd(G, 8'h0E, 8'h00);
    wr(G, 8'h0F, 8'h0D);
    rd(G, 8'h0F, 8'h6D);
    wr(G, 8'h0E, 8'h75);
    rd(G, 8'h0E, 8'h75);
    chk1("pclk", 1'h1, pclk);
    chk1("vid float", 1'h1, vid_oe_n);
    chk1("mem float", 1'h1, mem_oe_n);
    chk1("palette", 1'h1, pal);
    chk1("shift256", 1'h1, sh256);
    wr(G, 8'h0F, 8'h06);
    wr(G, 8'h0E, 8'h00);
    rd(G, 8'h0E, 8'h75);
    rd(G, 8'h0F, 8'h6E);
    end_test("lock");

    wr(C, 8'h2C, 8'h33);
    wr(C, 8'h29, 8'h85);
    rd(C, 8'h29, 8'h85);
    rd(C, 8'h2A, 8'hA0);
    wr(C, 8'h2A, 8'h6F);
    rd(C, 8'h2A, 8'h6F);
    chk1("emulation", 1'h1, emul);
    chk1("clock lock", 1'h1, clk_lock);
    chk1("gfx lock", 1'h1, gfx_lock);
    chk1("dot lock", 1'h1, dot_lock);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      misc <= m[1:0];
      settle();
      chk1("switch sense", SW_VAL[7 - m], sense);
    end
    wr(C, 8'h2B, 8'h80);
    wr(C, 8'h2C, 8'h5A);
    settle();
    chk1("converter off", 1'h1, dac_off);
    chk8("half start", 8'h5A, half);
    wr(C, 8'h29, 8'h84);
    wr(C, 8'h2C, 8'h11);
    rd(C, 8'h2C, 8'h5A);
    wr(C, 8'h29, 8'hD5);
    rd(C, 8'h29, 8'hD5);
    chk1("mfg test", 1'h1, mfg);
    wr(C, 8'h29, 8'h8D);
    rd(C, 8'h2C, 8'hFF);
    rd(C, 8'h29, 8'hFF);
    rd(G, 8'h10, 8'h00);
    end_test("upper");

    wr(G, 8'h0F, 8'h05);
    wr(G, 8'h0E, 8'h88);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      blank_in <= 1'h0;
      de_in <= 1'h1;
      pre_in <= 1'h0;
      de_sel <= s[0];
      a80 <= s[0];
      ilace <= s[0];
      settle();
      chk1("blank enable", s[0], blank_out);
      chk1("cga enable", s[0], cga_out);
      chk1("half enable", s[0], half_en);
    end
    wr(G, 8'h0E, 8'h02);
    settle();
    chk1("compat", 1'h1, compat);
    rd(G, 8'h0E, 8'hFF);
    rd(G, 8'h0F, 8'hFF);
    end_test("pins");

    pins <= 4'h5;
    do_reset();
    chk1("converter kept", 1'h1, dac_off);
    chk8("half kept", 8'h5A, half);
    chk1("compat cleared", 1'h0, compat);
    rd(C, 8'h29, 8'hFF);
    wr(C, 8'h29, 8'h85);
    rd(C, 8'h2A, 8'h50);
    end_test("second reset");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== src/dispctl_pkg.sv ====
/*
 * constants, state layout and request carrier for the extended display
 * control register bank. assumes one 40 MHz clock, CLK_IN.
 */
// Behaviour
// - bit7 puts display enable on blank pin
// - bit6 picks pixel clock source
// - bit5 floats pixel bus, syncs, blank
// - bit4 floats memory address and DRAM controls
// - bit3 forces colour video enable in 80x25
// - bit1 blocks legacy and first-register reads
// - bit0 selects 256-colour shift registers
// - lock bits reset 0, key 101 unlocks
// - status bits 7:3 show config straps
// - unlock register read/write, resets to 0
// - upper reads need bit7=1, bit3=0, else FF
// - upper writes need unlock bits 101
// - unlock bits 6:4 scratch, 101 reserved
// - switch bits 7:4 latched from straps
// - status bit4 returns selected switch bit (here only on SWITCH_SENSE_OUT; status bit4 reads a config strap)
// - switch bits 3:0 reset 0; emulation
// - switch bit2 freezes clock select
// - switch bit1 locks graphics/sequencer bits
// - switch bit0 locks 8/9 dot select
// - scratch bit7 shuts converter off
// - half-line start kept through reset
// - interlace enable activates half-line start
// - timing select picks early or coincident enable
package dispctl_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic SPACE_GFX = 1'b0;
  localparam logic SPACE_CRT = 1'b1;
  localparam logic [7:0] IDX_VCTL = 8'h0E;
  localparam logic [7:0] IDX_GSL = 8'h0F;
  localparam logic [7:0] IDX_UNLOCK = 8'h29;
  localparam logic [7:0] IDX_SW = 8'h2A;
  localparam logic [7:0] IDX_SCR = 8'h2B;
  localparam logic [7:0] IDX_HALF = 8'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int VC_DE_SEL = 7;
  localparam int VC_PCLK = 6;
  localparam int VC_TRI_VID = 5;
  localparam int VC_TRI_MEM = 4;
  localparam int VC_CGA_OVR = 3;
  localparam int VC_PAL_LOCK = 2;
  localparam int VC_COMPAT = 1;
  localparam int VC_SHIFT256 = 0;
  localparam int UL_RD_EN = 7;
  localparam int UL_RD_DIS = 3;
  localparam int SW_EMUL = 3;
  localparam int SW_LOCK_CLK = 2;
  localparam int SW_LOCK_GFX = 1;
  localparam int SW_LOCK_DOT = 0;
  localparam int SCR_DAC_OFF = 7;
  localparam logic [2:0] SW_STRAP_HI = 3'h7;

  // ****************************************
  // keys, reset and read-back values
  // ****************************************
  localparam logic [2:0] UNLOCK_KEY = 3'h5;
  localparam logic [2:0] LOCK_RST = 3'h0;
  localparam logic [7:0] VCTL_RST = 8'h00;
  localparam logic [7:0] UNLOCK_RST = 8'h00;
  localparam logic [7:0] SW_RST = 8'h00;
  localparam logic [7:0] RD_BLOCKED = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {STRAP_SYNC1, STRAP_SYNC2, STRAP_LATCH, STRAP_DONE} strap_e;

  typedef struct packed {
    logic space;
    logic [7:0] index;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } req_s;

  typedef struct packed {
    logic [7:0] vctl;
    logic [2:0] lock;
    logic [7:0] unlock;
    logic [7:0] sw;
    strap_e strap;
    logic [3:0] md_s1;
    logic [3:0] md_s2;
    logic [4:0] cnf_s1;
    logic [4:0] cnf_s2;
    logic [7:0] rdata;
    logic rvalid;
    logic blank;
    logic cga_en;
    logic sense;
    logic ilace;
    logic mfg;
  } state_s;

  typedef struct packed {
    logic [7:0] scratch;
    logic [7:0] half;
  } keep_s;

endpackage

// ==== src/display_ext_control_regs.sv ====
/*
 * extended display control register bank: video output control, lock
 * status, upper unlock, switches, scratch and half-line start.
 * assumes requests and timing inputs come from logic on CLK_IN; strap
 * pins come from outside and are synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
module display_ext_control_regs (
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  // indexed register access
  input wire dispctl_pkg::req_s REG_REQ_IN,
  output logic [7:0] RDATA_OUT,
  output logic RD_VALID_OUT,
  // strap pins
  input wire logic [3:0] MEM_DATA_STRAP_PINS_IN,
  input wire logic [4:0] STRAP_CONFIG_IN,
  // timing and mode inputs
  input wire logic BLANK_IN,
  input wire logic DISP_EN_IN,
  input wire logic PRE_DISP_EN_IN,
  input wire logic DE_TIMING_SEL_IN,
  input wire logic ALPHA80_CGA_IN,
  input wire logic CGA_VIDEO_EN_IN,
  input wire logic [1:0] MISC_SEL_IN,
  input wire logic INTERLACE_EN_IN,
  // video and memory pin control
  output logic BLANK_OUT,
  output logic PCLK_SRC_OUT,
  output logic VID_OE_N_OUT,
  output logic MEM_OE_N_OUT,
  output logic CGA_VIDEO_EN_OUT,
  output logic PALETTE_LOCK_OUT,
  output logic COMPAT_OUT,
  output logic SHIFT256_OUT,
  // switch and lock outputs
  output logic SWITCH_SENSE_OUT,
  output logic EMUL_ANALOG_OUT,
  output logic CLK_SEL_LOCK_OUT,
  output logic GFX_SEQ_LOCK_OUT,
  output logic DOT89_LOCK_OUT,
  output logic MFG_TEST_OUT,
  // converter and interlace
  output logic DAC_OFF_OUT,
  output logic [7:0] HALF_START_OUT,
  output logic HALF_START_EN_OUT
);

  // ****************************************
  // state
  // ****************************************
  dispctl_pkg::state_s st_r;
  dispctl_pkg::state_s st_nxt;
  dispctl_pkg::keep_s keep_r;
  dispctl_pkg::keep_s keep_nxt;

  logic gfx_hit;
  logic crt_hit;
  logic low_wr_ok;
  logic up_wr_ok;
  logic up_rd_ok;
  logic [2:0] sense_idx;

  always_comb begin
    gfx_hit = REG_REQ_IN.space == dispctl_pkg::SPACE_GFX;
    crt_hit = REG_REQ_IN.space == dispctl_pkg::SPACE_CRT;
    low_wr_ok = st_r.lock == dispctl_pkg::UNLOCK_KEY;
    up_wr_ok = st_r.unlock[2:0] == dispctl_pkg::UNLOCK_KEY;
    up_rd_ok = st_r.unlock[dispctl_pkg::UL_RD_EN] && !st_r.unlock[dispctl_pkg::UL_RD_DIS];
    sense_idx = dispctl_pkg::SW_STRAP_HI - {1'b0, MISC_SEL_IN};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    keep_nxt = keep_r;
    // synchroniser chains: first stage feeds only the second
    st_nxt.md_s1 = MEM_DATA_STRAP_PINS_IN;
    st_nxt.md_s2 = st_r.md_s1;
    st_nxt.cnf_s1 = STRAP_CONFIG_IN;
    st_nxt.cnf_s2 = st_r.cnf_s1;
    // writes; protected ones fall through untouched
    if (REG_REQ_IN.wr && gfx_hit) begin
      if (REG_REQ_IN.index == dispctl_pkg::IDX_VCTL && low_wr_ok) begin
        st_nxt.vctl = REG_REQ_IN.wdata;
      end
      if (REG_REQ_IN.index == dispctl_pkg::IDX_GSL) begin
        st_nxt.lock = REG_REQ_IN.wdata[2:0];
      end
    end
    if (REG_REQ_IN.wr && crt_hit) begin
      if (REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK) begin
        st_nxt.unlock = REG_REQ_IN.wdata;
      end
      if (up_wr_ok) begin
        if (REG_REQ_IN.index == dispctl_pkg::IDX_SW) begin
          st_nxt.sw = REG_REQ_IN.wdata;
        end
        if (REG_REQ_IN.index == dispctl_pkg::IDX_SCR) begin
          keep_nxt.scratch = REG_REQ_IN.wdata;
        end
        if (REG_REQ_IN.index == dispctl_pkg::IDX_HALF) begin
          keep_nxt.half = REG_REQ_IN.wdata;
        end
      end
    end
    // switch straps caught once, after the pins have crossed the synchroniser
    unique case (st_r.strap)
      dispctl_pkg::STRAP_SYNC1: st_nxt.strap = dispctl_pkg::STRAP_SYNC2;
      dispctl_pkg::STRAP_SYNC2: st_nxt.strap = dispctl_pkg::STRAP_LATCH;
      dispctl_pkg::STRAP_LATCH: begin
        st_nxt.sw[7:4] = st_r.md_s2;
        st_nxt.strap = dispctl_pkg::STRAP_DONE;
      end
      dispctl_pkg::STRAP_DONE: st_nxt.strap = dispctl_pkg::STRAP_DONE;
    endcase
    // reads: one-cycle registered answer
    st_nxt.rvalid = REG_REQ_IN.rd;
    st_nxt.rdata = dispctl_pkg::RD_UNMAPPED;
    if (REG_REQ_IN.rd && gfx_hit) begin
      if (REG_REQ_IN.index == dispctl_pkg::IDX_VCTL || REG_REQ_IN.index == dispctl_pkg::IDX_GSL) begin
        if (st_r.vctl[dispctl_pkg::VC_COMPAT]) begin
          st_nxt.rdata = dispctl_pkg::RD_BLOCKED;
        end else if (REG_REQ_IN.index == dispctl_pkg::IDX_VCTL) begin
          st_nxt.rdata = st_r.vctl;
        end else begin
          st_nxt.rdata = {st_r.cnf_s2[3:0], st_r.cnf_s2[4], st_r.lock};
        end
      end
    end
    if (REG_REQ_IN.rd && crt_hit) begin
      if (REG_REQ_IN.index >= dispctl_pkg::IDX_UNLOCK && REG_REQ_IN.index <= dispctl_pkg::IDX_HALF) begin
        if (!up_rd_ok) begin
          st_nxt.rdata = dispctl_pkg::RD_BLOCKED;
        end else if (REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK) begin
          st_nxt.rdata = st_r.unlock;
        end else if (REG_REQ_IN.index == dispctl_pkg::IDX_SW) begin
          st_nxt.rdata = st_r.sw;
        end else if (REG_REQ_IN.index == dispctl_pkg::IDX_SCR) begin
          st_nxt.rdata = keep_r.scratch;
        end else begin
          st_nxt.rdata = keep_r.half;
        end
      end
    end
    // pin-facing functions
    if (st_r.vctl[dispctl_pkg::VC_DE_SEL]) begin
      st_nxt.blank = DE_TIMING_SEL_IN ? DISP_EN_IN : PRE_DISP_EN_IN;
    end else begin
      st_nxt.blank = BLANK_IN;
    end
    st_nxt.cga_en = CGA_VIDEO_EN_IN || (st_r.vctl[dispctl_pkg::VC_CGA_OVR] && ALPHA80_CGA_IN);
    st_nxt.sense = st_r.sw[sense_idx];
    st_nxt.ilace = INTERLACE_EN_IN;
    // test pattern flag kept in a flop so the pin never glitches on decode
    st_nxt.mfg = st_nxt.unlock[6:4] == dispctl_pkg::UNLOCK_KEY;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_r <= '{vctl: dispctl_pkg::VCTL_RST, lock: dispctl_pkg::LOCK_RST,
                unlock: dispctl_pkg::UNLOCK_RST, sw: dispctl_pkg::SW_RST,
                strap: dispctl_pkg::STRAP_SYNC1, default: '0};
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // scratch and half-line start survive hardware reset, so no reset here
  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      keep_r <= keep_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // the pad ring resolves the wires; output enables here are active low
  assign RDATA_OUT = st_r.rdata;
  assign RD_VALID_OUT = st_r.rvalid;
  assign BLANK_OUT = st_r.blank;
  assign PCLK_SRC_OUT = st_r.vctl[dispctl_pkg::VC_PCLK];
  assign VID_OE_N_OUT = st_r.vctl[dispctl_pkg::VC_TRI_VID];
  assign MEM_OE_N_OUT = st_r.vctl[dispctl_pkg::VC_TRI_MEM];
  assign CGA_VIDEO_EN_OUT = st_r.cga_en;
  assign PALETTE_LOCK_OUT = st_r.vctl[dispctl_pkg::VC_PAL_LOCK];
  assign COMPAT_OUT = st_r.vctl[dispctl_pkg::VC_COMPAT];
  assign SHIFT256_OUT = st_r.vctl[dispctl_pkg::VC_SHIFT256];
  assign SWITCH_SENSE_OUT = st_r.sense;
  assign EMUL_ANALOG_OUT = st_r.sw[dispctl_pkg::SW_EMUL];
  assign CLK_SEL_LOCK_OUT = st_r.sw[dispctl_pkg::SW_LOCK_CLK];
  assign GFX_SEQ_LOCK_OUT = st_r.sw[dispctl_pkg::SW_LOCK_GFX];
  assign DOT89_LOCK_OUT = st_r.sw[dispctl_pkg::SW_LOCK_DOT];
  assign MFG_TEST_OUT = st_r.mfg;
  assign DAC_OFF_OUT = keep_r.scratch[dispctl_pkg::SCR_DAC_OFF];
  assign HALF_START_OUT = keep_r.half;
  assign HALF_START_EN_OUT = st_r.ilace;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // ****************************************
  // pin function checks
  // ****************************************
  blank_de_sel_a: assert property (
    CE_IN && st_r.vctl[dispctl_pkg::VC_DE_SEL] && DE_TIMING_SEL_IN
    |=> BLANK_OUT == $past(DISP_EN_IN))
    else $error("blank pin does not carry display enable");

  blank_pre_de_a: assert property (
    CE_IN && st_r.vctl[dispctl_pkg::VC_DE_SEL] && !DE_TIMING_SEL_IN
    |=> BLANK_OUT == $past(PRE_DISP_EN_IN))
    else $error("blank pin does not carry early display enable");

  blank_normal_a: assert property (
    CE_IN && !st_r.vctl[dispctl_pkg::VC_DE_SEL]
    |=> BLANK_OUT == $past(BLANK_IN))
    else $error("blank pin does not carry blanking");

  cga_force_a: assert property (
    CE_IN && st_r.vctl[dispctl_pkg::VC_CGA_OVR] && ALPHA80_CGA_IN
    |=> CGA_VIDEO_EN_OUT)
    else $error("colour enable not forced");

  cga_pass_a: assert property (
    CE_IN && !st_r.vctl[dispctl_pkg::VC_CGA_OVR]
    |=> CGA_VIDEO_EN_OUT == $past(CGA_VIDEO_EN_IN))
    else $error("colour enable altered without override");

  sense_sel_a: assert property (
    CE_IN && MISC_SEL_IN == 2'h0
    |=> SWITCH_SENSE_OUT == $past(st_r.sw[7]))
    else $error("switch sense selects wrong bit");

  sense_last_a: assert property (
    CE_IN && MISC_SEL_IN == 2'h3
    |=> SWITCH_SENSE_OUT == $past(st_r.sw[4]))
    else $error("switch sense misses lowest switch");

  ilace_follow_a: assert property (
    CE_IN
    |=> HALF_START_EN_OUT == $past(INTERLACE_EN_IN))
    else $error("interlace enable not followed");

  // ****************************************
  // write checks
  // ****************************************
  vctl_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && gfx_hit && REG_REQ_IN.index == dispctl_pkg::IDX_VCTL && low_wr_ok
    |=> {PCLK_SRC_OUT, VID_OE_N_OUT, MEM_OE_N_OUT} == $past(REG_REQ_IN.wdata[6:4]))
    else $error("video control write not applied");

  vctl_low_a: assert property (
    CE_IN && REG_REQ_IN.wr && gfx_hit && REG_REQ_IN.index == dispctl_pkg::IDX_VCTL && low_wr_ok
    |=> {PALETTE_LOCK_OUT, COMPAT_OUT, SHIFT256_OUT} == $past(REG_REQ_IN.wdata[2:0]))
    else $error("video control low bits not applied");

  vctl_locked_a: assert property (
    CE_IN && REG_REQ_IN.wr && gfx_hit && REG_REQ_IN.index == dispctl_pkg::IDX_VCTL && !low_wr_ok
    |=> $stable(st_r.vctl))
    else $error("locked video control changed");

  lock_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && gfx_hit && REG_REQ_IN.index == dispctl_pkg::IDX_GSL
    |=> st_r.lock == $past(REG_REQ_IN.wdata[2:0]))
    else $error("lock bits not written");

  unlock_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK
    |=> st_r.unlock == $past(REG_REQ_IN.wdata))
    else $error("unlock register not written");

  mfg_flag_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK
    && REG_REQ_IN.wdata[6:4] == dispctl_pkg::UNLOCK_KEY |=> MFG_TEST_OUT)
    else $error("test pattern flag not raised");

  sw_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && up_wr_ok && st_r.strap == dispctl_pkg::STRAP_DONE
    && REG_REQ_IN.index == dispctl_pkg::IDX_SW |=> st_r.sw == $past(REG_REQ_IN.wdata))
    else $error("open switch write not applied");

  sw_locked_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && !up_wr_ok && st_r.strap == dispctl_pkg::STRAP_DONE
    && REG_REQ_IN.index == dispctl_pkg::IDX_SW |=> $stable(st_r.sw))
    else $error("protected switch write took effect");

  scratch_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && up_wr_ok && REG_REQ_IN.index == dispctl_pkg::IDX_SCR
    |=> DAC_OFF_OUT == $past(REG_REQ_IN.wdata[dispctl_pkg::SCR_DAC_OFF]))
    else $error("converter control not written");

  half_write_a: assert property (
    CE_IN && REG_REQ_IN.wr && crt_hit && up_wr_ok && REG_REQ_IN.index == dispctl_pkg::IDX_HALF
    |=> HALF_START_OUT == $past(REG_REQ_IN.wdata))
    else $error("half-line start not written");

  // ****************************************
  // read checks
  // ****************************************
  read_pulse_a: assert property (
    CE_IN && REG_REQ_IN.rd
    |=> RD_VALID_OUT)
    else $error("read answer missing");

  compat_read_a: assert property (
    CE_IN && REG_REQ_IN.rd && gfx_hit && st_r.vctl[dispctl_pkg::VC_COMPAT]
    && REG_REQ_IN.index == dispctl_pkg::IDX_VCTL |=> RD_VALID_OUT && RDATA_OUT == dispctl_pkg::RD_BLOCKED)
    else $error("compatibility read not blocked");

  status_blocked_a: assert property (
    CE_IN && REG_REQ_IN.rd && gfx_hit && st_r.vctl[dispctl_pkg::VC_COMPAT]
    && REG_REQ_IN.index == dispctl_pkg::IDX_GSL |=> RDATA_OUT == dispctl_pkg::RD_BLOCKED)
    else $error("status read not blocked");

  status_read_a: assert property (
    CE_IN && REG_REQ_IN.rd && gfx_hit && !st_r.vctl[dispctl_pkg::VC_COMPAT]
    && REG_REQ_IN.index == dispctl_pkg::IDX_GSL
    |=> RDATA_OUT[7:3] == {$past(st_r.cnf_s2[3:0]), $past(st_r.cnf_s2[4])})
    else $error("strap status read wrong");

  upper_read_a: assert property (
    CE_IN && REG_REQ_IN.rd && crt_hit && !up_rd_ok
    && REG_REQ_IN.index == dispctl_pkg::IDX_SW |=> RDATA_OUT == dispctl_pkg::RD_BLOCKED)
    else $error("protected upper read leaked");

  unlock_blocked_a: assert property (
    CE_IN && REG_REQ_IN.rd && crt_hit && !up_rd_ok
    && REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK |=> RDATA_OUT == dispctl_pkg::RD_BLOCKED)
    else $error("protected unlock read leaked");

  unlock_read_a: assert property (
    CE_IN && REG_REQ_IN.rd && crt_hit && up_rd_ok
    && REG_REQ_IN.index == dispctl_pkg::IDX_UNLOCK |=> RDATA_OUT == $past(st_r.unlock))
    else $error("unlock read wrong");

  sw_read_a: assert property (
    CE_IN && REG_REQ_IN.rd && crt_hit && up_rd_ok
    && REG_REQ_IN.index == dispctl_pkg::IDX_SW |=> RDATA_OUT == $past(st_r.sw))
    else $error("switch read wrong");

  // ****************************************
  // strap capture checks
  // ****************************************
  strap_latch_a: assert property (
    CE_IN && st_r.strap == dispctl_pkg::STRAP_LATCH
    |=> st_r.sw[7:4] == $past(st_r.md_s2))
    else $error("switch straps not latched");

  strap_start_a: assert property (
    CE_IN && st_r.strap == dispctl_pkg::STRAP_SYNC1
    |=> st_r.strap == dispctl_pkg::STRAP_SYNC2)
    else $error("strap capture did not advance");

  strap_hold_a: assert property (
    CE_IN && st_r.strap == dispctl_pkg::STRAP_DONE
    |=> st_r.strap == dispctl_pkg::STRAP_DONE)
    else $error("straps captured again");

  // ****************************************
  // covers
  // ****************************************

  unlock_use_c: cover property (REG_REQ_IN.wr && crt_hit && up_wr_ok && REG_REQ_IN.index == dispctl_pkg::IDX_SW);
  upper_read_c: cover property (REG_REQ_IN.rd && crt_hit && up_rd_ok);
  de_mode_c: cover property (st_r.vctl[7] && DE_TIMING_SEL_IN);
  tri_state_c: cover property (VID_OE_N_OUT && MEM_OE_N_OUT);

endmodule
`default_nettype wire
